// file: pkg/sipo_regs.svh
// Constants shared by the shift and holding latch block
`ifndef SIPO_REGS_SVH
`define SIPO_REGS_SVH
`define SIPO_STAGES 8
`define SIPO_FIFO_DEPTH 16
`define SIPO_CLEAR_VALUE 8'h00
`define SIPO_OE_IDLE 1'h1
`endif

// file: pkg/sipo_pkg.sv
// Types for the shift and holding latch block
`default_nettype none
`include "sipo_regs.svh"
package sipo_pkg;
	typedef logic [`SIPO_STAGES-1:0] stage_word_t;
	typedef struct packed {
		logic drive;
		stage_word_t value;
	} parallel_pins_s;
endpackage
`default_nettype wire

// file: verilog/serial_in_parallel_out_latch.sv
// Serial-in parallel-out shift stages, holding latch and output FIFO
`default_nettype none
`include "sipo_regs.svh"

module sipo_async_fifo #(
	parameter int WIDTH = `SIPO_STAGES,
	parameter int DEPTH = `SIPO_FIFO_DEPTH
) (
	input wire logic wclk,
	input wire logic wrstn,
	input wire logic wvalid,
	output logic wready,
	input wire logic [WIDTH-1:0] wdata,
	input wire logic rclk,
	input wire logic rrstn,
	output logic rvalid,
	input wire logic rready,
	output logic [WIDTH-1:0] rdata
);
	localparam int AW = $clog2(DEPTH);
	typedef logic [AW:0] ptr_t;
	typedef struct packed {
		ptr_t bin;
		ptr_t gray;
		ptr_t sync1;
		ptr_t sync2;
	} side_s;

	logic [WIDTH-1:0] mem [DEPTH];
	side_s wst, next_wst, rst, next_rst;
	logic push, pop;

	// Full when the write gray pointer leads by one whole lap
	assign wready = wst.gray != {~wst.sync2[AW:AW-1], wst.sync2[AW-2:0]};
	assign rvalid = rst.gray != rst.sync2;
	assign push = wvalid & wready;
	assign pop = rvalid & rready;
	assign rdata = mem[rst.bin[AW-1:0]];

	// Read pointer reaches this side only on latch edges, so full
	// is reported early, never late
	always_comb begin
		next_wst = wst;
		next_wst.sync1 = rst.gray;
		next_wst.sync2 = wst.sync1;
		if (push) begin
			next_wst.bin = ptr_t'(wst.bin + 1'b1);
		end
		next_wst.gray = next_wst.bin ^ (next_wst.bin >> 1);
	end

	always_ff @(posedge wclk or negedge wrstn) begin
		if (!wrstn) begin
			wst <= '0;
		end else begin
			wst <= next_wst;
		end
	end

	// Memory kept outside the reset struct; contents need no reset
	always_ff @(posedge wclk) begin
		if (push) begin
			mem[wst.bin[AW-1:0]] <= wdata;
		end
	end

	always_comb begin
		next_rst = rst;
		next_rst.sync1 = wst.gray;
		next_rst.sync2 = rst.sync1;
		if (pop) begin
			next_rst.bin = ptr_t'(rst.bin + 1'b1);
		end
		next_rst.gray = next_rst.bin ^ (next_rst.bin >> 1);
	end

	always_ff @(posedge rclk or negedge rrstn) begin
		if (!rrstn) begin
			rst <= '0;
		end else begin
			rst <= next_rst;
		end
	end

	property p_no_overflow;
		@(posedge wclk) disable iff (!wrstn)
		!wready |=> wst.bin == $past(wst.bin);
	endproperty
	a_no_overflow: assert property (p_no_overflow)
		else $error("fifo pointer moved while full");

	property p_no_underflow;
		@(posedge rclk) disable iff (!rrstn)
		!rvalid |=> rst.bin == $past(rst.bin);
	endproperty
	a_no_underflow: assert property (p_no_underflow)
		else $error("fifo pointer moved while empty");
endmodule

// Behaviour
// (R01) Eight shift stages load serially and feed the holding latch in parallel.
// (R02) Shift stages and latch have their own clocks, rising edge only.
// (R03) Each shift edge moves stages up one; first stage takes serial input.
// (R04) Clear low forces every shift stage to zero at once.
// (R05) Latch edge captures all eight stages; outputs show them when enabled.
// (R06) Output enable high floats the parallel outputs; low drives latch value.
// (R07) Last stage always drives the serial cascade output.
// (R08) With clocks tied, latch takes the stages from before the shared edge.
// (R09) Latch keeps its value between latch edges whatever else changes; code also clears it whenever rstn goes low.
// (R10) Controller shifts all bits of the chain before raising latch clock.
module serial_in_parallel_out_latch #(
	parameter int DEPTH = `SIPO_FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic shiftClock,
	input wire logic latchClock,
	input wire logic shiftClearN,
	input wire logic serialIn,
	input wire logic outputEnableN,
	output logic serialCascade,
	output sipo_pkg::parallel_pins_s parallelOut
);
	typedef struct packed {
		sipo_pkg::stage_word_t stages;
	} shift_s;
	typedef struct packed {
		sipo_pkg::stage_word_t held;
	} latch_s;
	typedef struct packed {
		logic oeSync1;
		logic oeSync2;
		sipo_pkg::parallel_pins_s pins;
	} out_s;

	shift_s shiftSt, next_shiftSt;
	latch_s latchSt, next_latchSt;
	out_s outSt, next_outSt;
	logic clearN;
	logic pushReady;
	logic popValid;
	sipo_pkg::stage_word_t popData;

	// Power-on reset also empties the stages, not only the clear pin
	assign clearN = shiftClearN & rstn;

	always_comb begin
		next_shiftSt = shiftSt;
		next_shiftSt.stages = {shiftSt.stages[`SIPO_STAGES-2:0], serialIn}; // [R01] [R03]
	end

	// Clear needs no clock edge and overrides any shift
	always_ff @(posedge shiftClock or negedge clearN) begin // [R02]
		if (!clearN) begin
			shiftSt.stages <= `SIPO_CLEAR_VALUE; // [R04]
		end else begin
			shiftSt <= next_shiftSt;
		end
	end

	// Straight off the last stage so chained parts see every shift
	assign serialCascade = shiftSt.stages[`SIPO_STAGES-1]; // [R07]

	// Old stage values seen at the edge give the one-clock lag
	always_comb begin
		next_latchSt = latchSt;
		next_latchSt.held = shiftSt.stages; // [R05] [R08]
	end

	// Clear acts on the stages only; the latch keeps its word
	always_ff @(posedge latchClock or negedge rstn) begin // [R02]
		if (!rstn) begin
			latchSt <= '0;
		end else begin
			latchSt <= next_latchSt; // [R09]
		end
	end

	// Captures cross to clk as whole words; a full FIFO drops the capture
	sipo_async_fifo #(
		.WIDTH(`SIPO_STAGES),
		.DEPTH(DEPTH)
	) sipo_async_fifo_i (
		.wclk(latchClock),
		.wrstn(rstn),
		.wvalid(1'b1),
		.wready(pushReady),
		.wdata(shiftSt.stages),
		.rclk(clk),
		.rrstn(rstn),
		.rvalid(popValid),
		.rready(1'b1),
		.rdata(popData)
	);

	// Value follows captures even while floating
	always_comb begin
		next_outSt = outSt;
		next_outSt.oeSync1 = outputEnableN;
		next_outSt.oeSync2 = outSt.oeSync1;
		next_outSt.pins.drive = !outSt.oeSync2; // [R06]
		if (popValid) begin
			next_outSt.pins.value = popData; // [R05]
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			// Syncs idle as disabled so reset never turns the pins on
			outSt.oeSync1 <= `SIPO_OE_IDLE;
			outSt.oeSync2 <= `SIPO_OE_IDLE;
			outSt.pins <= '0;
		end else begin
			outSt <= next_outSt; // [R09]
		end
	end

	assign parallelOut = outSt.pins;

	sequence s_oeHigh;
		outputEnableN [*3];
	endsequence
	sequence s_oeLow;
		!outputEnableN [*3];
	endsequence

	property p_oe_float;
		@(posedge clk) disable iff (!rstn)
		s_oeHigh |=> !parallelOut.drive;
	endproperty
	a_oe_float: assert property (p_oe_float) // [R06]
		else $error("parallel outputs driven while disabled");

	property p_oe_drive;
		@(posedge clk) disable iff (!rstn)
		s_oeLow |=> parallelOut.drive;
	endproperty
	a_oe_drive: assert property (p_oe_drive) // [R06]
		else $error("parallel outputs not driven while enabled");

	property p_one_travels;
		@(posedge shiftClock) disable iff (!clearN)
		serialIn |-> ##8 serialCascade;
	endproperty
	a_one_travels: assert property (p_one_travels) // [R03]
		else $error("one did not reach cascade after eight shifts");

	property p_zero_travels;
		@(posedge shiftClock) disable iff (!clearN)
		!serialIn |-> ##8 !serialCascade;
	endproperty
	a_zero_travels: assert property (p_zero_travels) // [R01]
		else $error("zero did not reach cascade after eight shifts");

	property p_clear_zero;
		@(posedge clk) disable iff (!rstn)
		!shiftClearN [*2] |-> !serialCascade && shiftSt.stages == '0;
	endproperty
	a_clear_zero: assert property (p_clear_zero) // [R04]
		else $error("stages not zero under clear");

	property p_latch_lag;
		@(posedge latchClock) disable iff (!rstn)
		1'b1 |=> latchSt.held == $past(shiftSt.stages);
	endproperty
	a_latch_lag: assert property (p_latch_lag) // [R08]
		else $error("latch did not take the pre-edge stages");

	property p_out_update;
		@(posedge clk) disable iff (!rstn)
		popValid |=> parallelOut.value == $past(popData);
	endproperty
	a_out_update: assert property (p_out_update) // [R05]
		else $error("output value missed a captured word");

	property p_out_hold;
		@(posedge clk) disable iff (!rstn)
		!popValid |=> $stable(parallelOut.value);
	endproperty
	a_out_hold: assert property (p_out_hold) // [R09]
		else $error("output value changed without a capture");

	property p_shift_step;
		@(posedge shiftClock) disable iff (!clearN)
		1'b1 |=> shiftSt.stages ==
			{$past(shiftSt.stages[`SIPO_STAGES-2:0]), $past(serialIn)};
	endproperty
	a_shift_step: assert property (p_shift_step) // [R03]
		else $error("shift stages did not move up by one");

	// Latch pulses outlast one clk period, so an edge cannot hide
	sequence s_latchIdle;
		!latchClock [*2];
	endsequence
	property p_held_stable;
		@(posedge clk) disable iff (!rstn)
		s_latchIdle |-> $stable(latchSt.held);
	endproperty
	a_held_stable: assert property (p_held_stable) // [R09]
		else $error("holding latch changed without a latch edge");
endmodule
`default_nettype wire

// file: verification/sipo_host_model.sv
// Host controller model driving the serial link
`default_nettype none
module sipo_host_model (
	output logic shiftClock,
	output logic latchClock,
	output logic serialIn
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		shiftClock = 1'b0;
		latchClock = 1'b0;
		serialIn = 1'b0;
	end
	// One 48 ns link period; clocks idle low between frames
	task automatic pulse(input logic s, input logic l, input logic d);
		serialIn = d;
		#12 shiftClock = s;
		latchClock = l;
		// Hold over: stale data must not look valid
		#12 serialIn = ~d;
		#12 shiftClock = 1'b0;
		latchClock = 1'b0;
		#12;
	endtask
	// First bit sent ends on the cascade stage
	task automatic send(input logic [7:0] w);
		for (int i = 7; i >= 0; i--) begin
			pulse(1'b1, 1'b0, w[i]);
		end
	endtask
endmodule
`default_nettype wire

// file: verification/serial_in_parallel_out_latch_tb_top.sv
// Self-checking bench for the shift and holding latch block
`default_nettype none
module serial_in_parallel_out_latch_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk, rstn, shiftClearN, outputEnableN;
	wire shiftClock, latchClock, serialIn, serialCascade;
	sipo_pkg::parallel_pins_s parallelOut;
	wire [7:0] pins;
	int fail_count = 0;
	int checks_done = 0;
	// Pins float when the block stops driving
	assign pins = parallelOut.drive ? parallelOut.value : 8'hZZ;
	sipo_host_model sipo_host_model_i (
		.shiftClock(shiftClock),
		.latchClock(latchClock),
		.serialIn(serialIn)
	);
	serial_in_parallel_out_latch serial_in_parallel_out_latch_i (
		.clk(clk),
		.rstn(rstn),
		.shiftClock(shiftClock),
		.latchClock(latchClock),
		.shiftClearN(shiftClearN),
		.serialIn(serialIn),
		.outputEnableN(outputEnableN),
		.serialCascade(serialCascade),
		.parallelOut(parallelOut)
	);
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic chk(input string what, input logic [7:0] e,
		input logic [7:0] g);
		checks_done++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic close_out();
		if (fail_count == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// Covers the clk-domain sync lag of the pins
	task automatic settle();
		repeat (6) @(posedge clk);
		#1;
	endtask
	task automatic latch_now();
		sipo_host_model_i.pulse(1'b0, 1'b1, 1'b0);
		settle();
	endtask
	task automatic t_load();
		sipo_host_model_i.send(8'hA5);
		chk("cascade", 8'h01, {7'h00, serialCascade});
		latch_now();
		chk("pins", 8'hA5, pins);
		sipo_host_model_i.send(8'h3C);
		chk("held", 8'hA5, pins);
		latch_now();
		chk("pins", 8'h3C, pins);
	endtask
	task automatic t_clear();
		sipo_host_model_i.send(8'hFF);
		@(posedge clk);
		#1 shiftClearN = 1'b0;
		#1 chk("cleared", 8'h00, {7'h00, serialCascade});
		sipo_host_model_i.pulse(1'b1, 1'b0, 1'b1);
		chk("ignored", 8'h00, {7'h00, serialCascade});
		chk("held", 8'h3C, pins);
		latch_now();
		chk("pins", 8'h00, pins);
		shiftClearN = 1'b1;
		settle();
	endtask
	task automatic t_enable();
		outputEnableN = 1'b1;
		settle();
		chk("float", 8'hZZ, pins);
		sipo_host_model_i.send(8'h81);
		latch_now();
		outputEnableN = 1'b0;
		settle();
		chk("pins", 8'h81, pins);
	endtask
	task automatic t_tied();
		sipo_host_model_i.send(8'h96);
		sipo_host_model_i.pulse(1'b1, 1'b1, 1'b1);
		settle();
		chk("lag", 8'h96, pins);
		latch_now();
		chk("pins", 8'h2D, pins);
	endtask
	initial begin
		rstn = 1'b0;
		shiftClearN = 1'b1;
		outputEnableN = 1'b0;
		repeat (4) @(posedge clk);
		#1 rstn = 1'b1;
		settle();
		chk("reset", 8'h00, pins);
		t_load();
		t_clear();
		t_enable();
		t_tied();
		close_out();
	end
	// Run takes about 2.5 us; limit leaves ample margin
	initial begin
		#20000;
		fail_count++;
		close_out();
	end
endmodule
`default_nettype wire
